//--- common/pdareg_pkg.sv
// Purpose: shared constants for the demo application register and memory block
// Assumes: AHB-Lite slave, 32-bit data, one aligned word per register
// Notes:   bit 16 of the address picks the second memory window
package pdareg_pkg;

  localparam int unsigned    ADDR_W          = 32;
  localparam int unsigned    DATA_W          = 32;
  localparam int unsigned    WIN_SEL_BIT     = 16;

  // window 0 register offsets
  localparam logic [15:0]    OFF_CTRL        = 16'h0000;
  localparam logic [15:0]    OFF_RELOAD      = 16'h0004;
  localparam logic [15:0]    OFF_COUNT       = 16'h0008;
  localparam logic [15:0]    OFF_SWITCH      = 16'h000C;
  localparam logic [15:0]    OFF_SEGMENT     = 16'h0010;

  // window 1 block_ram_store placement
  localparam logic [15:0]    RAM_BASE        = 16'h1000;
  localparam int unsigned    RAM_BYTES_DEF   = 16384;

  // field positions and widths
  localparam int unsigned    CTRL_RUN_BIT    = 0;
  localparam int unsigned    SWITCH_W        = 8;
  localparam int unsigned    SEGMENT_W       = 14;

  // values after reset
  localparam logic [31:0]    RELOAD_RST      = 32'h0000_0000;
  localparam logic [31:0]    COUNT_RST       = 32'h0000_0000;
  localparam logic [13:0]    SEGMENT_RST     = 14'h0000;

  // AHB codes
  localparam logic [2:0]     HSIZE_BYTE      = 3'h0;
  localparam logic [2:0]     HSIZE_HALF      = 3'h1;
  localparam logic [2:0]     HSIZE_WORD      = 3'h2;
  localparam logic           HRESP_OKAY      = 1'b0;

  // read data phase has this many wait states; data is ready in the cycle after them
  localparam int unsigned    RD_WAIT_CYCLES  = 2;

  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_WR,
    BUS_RD1,
    BUS_RD2
  } pdareg_bus_e;

  typedef enum logic [2:0] {
    SEL_CTRL,
    SEL_RELOAD,
    SEL_COUNT,
    SEL_SWITCH,
    SEL_SEGMENT,
    SEL_RAM,
    SEL_NONE
  } pdareg_sel_e;

endpackage : pdareg_pkg

//--- rtl/pdareg_top.sv
// Purpose: demo application registers: down counter, switch bank, segment
//          display control and block_ram_store, as an AHB-Lite slave
// Assumes: one clock hclk; board_switch_bank inputs synchronous to hclk
// Notes:   reads take two wait states, writes none; response always OKAY
//
// The implementer's own choices: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none

module pdareg_top
  import pdareg_pkg::*;
#(
  parameter int unsigned RAM_BYTES = RAM_BYTES_DEF
) (
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  input  wire logic                 hsel,
  input  wire logic [ADDR_W-1:0]    haddr,
  input  wire logic [1:0]           htrans,
  input  wire logic                 hwrite,
  input  wire logic [2:0]           hsize,
  input  wire logic [DATA_W-1:0]    hwdata,
  input  wire logic                 hready,
  output logic      [DATA_W-1:0]    hrdata,
  output logic                      hreadyout,
  output logic                      hresp,
  input  wire logic [SWITCH_W-1:0]  board_switch_bank,
  output logic      [SEGMENT_W-1:0] seg_out_n
);

  localparam int unsigned RAM_WORDS = RAM_BYTES / 4;
  localparam int unsigned RAM_AW    = $clog2(RAM_WORDS);

  if (RAM_BYTES < 8 || (RAM_BYTES & (RAM_BYTES - 1)) != 0 ||
      RAM_BYTES > 32'h0001_0000 - 32'(RAM_BASE)) begin : g_bad_ram
    $error("RAM_BYTES must be a power of two that fits the second window");
  end

  // byte lanes of one access
  function automatic logic [3:0] lane_mask(input logic [2:0] size, input logic [1:0] a);
    logic [3:0] m;
    m = 4'hF;
    case (size)
      HSIZE_BYTE: m = 4'(4'h1 << a);
      HSIZE_HALF: m = a[1] ? 4'hC : 4'h3;
      default:    m = 4'hF;
    endcase
    return m;
  endfunction : lane_mask

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  function automatic pdareg_sel_e decode(input logic [ADDR_W-1:0] a);
    pdareg_sel_e s;
    logic [15:0] off;
    s = SEL_NONE;
    off = {a[15:2], 2'b00};
    if (a[WIN_SEL_BIT]) begin
      if (off >= RAM_BASE && 32'(off) < 32'(RAM_BASE) + RAM_BYTES) begin
        s = SEL_RAM;
      end
    end else begin
      case (off)
        OFF_CTRL:    s = SEL_CTRL;
        OFF_RELOAD:  s = SEL_RELOAD;
        OFF_COUNT:   s = SEL_COUNT;
        OFF_SWITCH:  s = SEL_SWITCH;
        OFF_SEGMENT: s = SEL_SEGMENT;
        default:     s = SEL_NONE;
      endcase
    end
    return s;
  endfunction : decode

  pdareg_bus_e            state_r;
  pdareg_sel_e            sel_r;
  logic [RAM_AW-1:0]      ram_idx_r;
  logic [3:0]             be_r;
  logic [31:0]            hrdata_r;
  logic                   hreadyout_r;
  logic                   hresp_r;
  logic                   run_r;
  logic [31:0]            reload_r;
  logic [31:0]            count_r;
  logic [SWITCH_W-1:0]    sw_r;
  logic [SEGMENT_W-1:0]   seg_r;
  logic [SEGMENT_W-1:0]   seg_out_r;
  logic [31:0]            ram_q_r;
  logic [31:0]            mem [0:RAM_WORDS-1];

  logic                   accept;
  logic                   wr_phase;
  logic                   start_w;
  logic [RAM_AW-1:0]      ram_idx_nxt;
  logic [15:0]            ram_off;

  assign accept      = hsel && htrans[1] && hready;
  assign wr_phase    = (state_r == BUS_WR);
  assign ram_off     = 16'(haddr[15:0] - RAM_BASE);
  assign ram_idx_nxt = ram_off[RAM_AW+1:2];
  // counting starts on a write that sets run while halted
  assign start_w     = wr_phase && sel_r == SEL_CTRL && be_r[0] &&
                       hwdata[CTRL_RUN_BIT] && !run_r;

  // transfer sequencing
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r     <= BUS_IDLE;
      sel_r       <= SEL_NONE;
      ram_idx_r   <= '0;
      be_r        <= 4'h0;
      hreadyout_r <= 1'b1;
    end else begin
      unique case (state_r)
        BUS_IDLE, BUS_WR: begin
          state_r <= BUS_IDLE;
          if (accept) begin
            sel_r     <= decode(haddr);
            ram_idx_r <= ram_idx_nxt;
            be_r      <= lane_mask(hsize, haddr[1:0]);
            if (hwrite) begin
              state_r <= BUS_WR;
            end else begin
              state_r     <= BUS_RD1;
              hreadyout_r <= 1'b0;
            end
          end
        end
        BUS_RD1: begin
          state_r <= BUS_RD2;
        end
        BUS_RD2: begin
          state_r     <= BUS_IDLE;
          hreadyout_r <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp_r <= HRESP_OKAY;
    end else begin
      hresp_r <= HRESP_OKAY;
    end
  end

  // read data mux, whole word; master picks its lanes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_r <= 32'h0000_0000;
    end else if (state_r == BUS_RD2) begin
      unique case (sel_r)
        SEL_CTRL:    hrdata_r <= 32'({run_r});
        SEL_RELOAD:  hrdata_r <= reload_r;
        SEL_COUNT:   hrdata_r <= count_r;
        SEL_SWITCH:  hrdata_r <= 32'(sw_r);
        SEL_SEGMENT: hrdata_r <= 32'(seg_r);
        SEL_RAM:     hrdata_r <= ram_q_r;
        SEL_NONE:    hrdata_r <= 32'h0000_0000;
      endcase
    end
  end

  // block_ram_store, read in the first wait state so a write just before is seen
  always_ff @(posedge hclk) begin
    if (wr_phase && sel_r == SEL_RAM) begin
      mem[ram_idx_r] <= merge(mem[ram_idx_r], hwdata, be_r);
    end
    if (state_r == BUS_RD1) begin
      ram_q_r <= mem[ram_idx_r];
    end
  end

  // run control
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_r <= 1'b0;
    end else if (wr_phase && sel_r == SEL_CTRL && be_r[0]) begin
      run_r <= hwdata[CTRL_RUN_BIT];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reload_r <= RELOAD_RST;
    end else if (wr_phase && sel_r == SEL_RELOAD) begin
      reload_r <= merge(reload_r, hwdata, be_r);
    end
  end

  // down counter, one step per hclk edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_r <= COUNT_RST;
    end else if (start_w) begin
      count_r <= reload_r;
    end else if (run_r) begin
      if (count_r == 32'h0000_0000) begin
        count_r <= reload_r;
      end else begin
        count_r <= count_r - 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sw_r <= '0;
    end else begin
      sw_r <= board_switch_bank;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seg_r <= SEGMENT_RST;
    end else if (wr_phase && sel_r == SEL_SEGMENT) begin
      seg_r <= SEGMENT_W'(merge(32'(seg_r), hwdata, be_r));
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      seg_out_r <= ~SEGMENT_RST;
    end else begin
      seg_out_r <= ~seg_r;
    end
  end

  assign hrdata    = hrdata_r;
  assign hreadyout = hreadyout_r;
  assign hresp     = hresp_r;
  assign seg_out_n = seg_out_r;

  // checks
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  AST_COUNT_DEC: assert property (
    run_r && !start_w && count_r != 32'h0 |=> count_r == $past(count_r) - 32'h1)
    else $error("counter did not step down by one");

  AST_COUNT_HALT: assert property (
    !run_r && !start_w |=> $stable(count_r))
    else $error("counter moved while halted");

  AST_START_LOAD: assert property (
    start_w |=> run_r && count_r == $past(reload_r))
    else $error("start did not load the reload value");

  AST_WRAP_RELOAD: assert property (
    run_r && !start_w && count_r == 32'h0 |=> count_r == $past(reload_r))
    else $error("counter did not reload at zero");

  AST_SEG_INV: assert property (
    $past(hresetn) |-> seg_out_n == ~$past(seg_r))
    else $error("display output is not the inverse of the segment register");

  AST_SEG_WRITE: assert property (
    wr_phase && sel_r == SEL_SEGMENT && be_r == 4'hF |=> seg_r == $past(hwdata[13:0]))
    else $error("segment register write lost");

  AST_RD_COUNT: assert property (
    accept && !hwrite && decode(haddr) == SEL_COUNT
      |=> !hreadyout ##1 !hreadyout ##1 hreadyout && hrdata == $past(count_r))
    else $error("count read wrong or late");

  AST_RD_SWITCH: assert property (
    state_r == BUS_RD2 && sel_r == SEL_SWITCH |=> hrdata == 32'($past(sw_r)))
    else $error("switch read does not match switch bank");

  AST_RD_UNMAPPED: assert property (
    state_r == BUS_RD2 && sel_r == SEL_NONE |=> hreadyout && hrdata == 32'h0 && hresp == 1'b0)
    else $error("unmapped read did not return zero");

  AST_RAM_WINDOW: assert property (
    accept && haddr[WIN_SEL_BIT] && haddr[15:0] == RAM_BASE |=> sel_r == SEL_RAM && ram_idx_r == '0)
    else $error("window offset 0x1000 is not the first RAM word");

  AST_BYTE_LANE: assert property (
    accept && hsize == HSIZE_BYTE |=> $onehot(be_r) && be_r[$past(haddr[1:0])])
    else $error("byte access used the wrong lane");

  AST_RAM_READBACK: assert property (
    wr_phase && sel_r == SEL_RAM && be_r == 4'hF ##1 accept && !hwrite &&
      decode(haddr) == SEL_RAM && ram_idx_nxt == $past(ram_idx_r)
      |=> ##2 hrdata == $past(hwdata, 4))
    else $error("RAM word did not read back as written");

  AST_RESP_OKAY: assert property (
    hresp == HRESP_OKAY)
    else $error("slave response was not OKAY");

  AST_WR_NO_WAIT: assert property (
    accept && hwrite |=> hreadyout)
    else $error("write data phase was stretched");

  AST_RD_TWO_WAITS: assert property (
    accept && !hwrite |=> !hreadyout ##1 !hreadyout ##1 hreadyout)
    else $error("read did not finish after two wait states");

  AST_RUN_READ: assert property (
    state_r == BUS_RD2 && sel_r == SEL_CTRL |=> hrdata == 32'($past(run_r)))
    else $error("control read does not show the run bit");

  AST_RELOAD_WRITE: assert property (
    wr_phase && sel_r == SEL_RELOAD && be_r == 4'hF |=> reload_r == $past(hwdata))
    else $error("reload write lost");

  AST_SWITCH_SAMPLE: assert property (
    $past(hresetn) |-> sw_r == $past(board_switch_bank))
    else $error("switch register is not one clock behind the pins");

  AST_HALF_LANE: assert property (
    accept && hsize == HSIZE_HALF |=> be_r == ($past(haddr[1]) ? 4'hC : 4'h3))
    else $error("halfword access used the wrong lanes");

  CVR_COUNT_WHILE_RUN: cover property (run_r && state_r == BUS_RD2 && sel_r == SEL_COUNT);
  CVR_WRAP: cover property (run_r && count_r == 32'h0);
  CVR_RAM_BYTE_WRITE: cover property (wr_phase && sel_r == SEL_RAM && $onehot(be_r));
  CVR_UNMAPPED_READ: cover property (state_r == BUS_RD2 && sel_r == SEL_NONE);
  CVR_RAM_WR_RD: cover property (wr_phase && sel_r == SEL_RAM ##1 accept && !hwrite);

endmodule : pdareg_top

`default_nettype wire

//--- testbench/pdareg_host.sv
// Purpose: AHB-Lite master standing in for the endpoint core
// Assumes: single whole-word transfers, one slave
// Notes:   signals change by nonblocking assignment after a rising edge
`timescale 1ns/1ns
`default_nettype none

module pdareg_host
  import pdareg_pkg::*;
(
  input  wire logic              hclk,
  input  wire logic              hreadyout,
  input  wire logic [DATA_W-1:0] hrdata,
  output logic                   hsel,
  output logic      [ADDR_W-1:0] haddr,
  output logic      [1:0]        htrans,
  output logic                   hwrite,
  output logic      [2:0]        hsize,
  output logic      [DATA_W-1:0] hwdata
);

  initial begin
    hsel   = 1'h0;
    haddr  = '0;
    htrans = 2'h0;
    hwrite = 1'h0;
    hsize  = HSIZE_WORD;
    hwdata = '0;
  end

  // called right after a rising edge, so a read may follow a write back to back
  // waits on hready for each phase, no latency assumed
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    hsel   <= 1'h1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    hsel   <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wr ? wd : ~hwdata;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    rd = hrdata;
    // released data lines must not keep the last value
    hwdata <= ~hwdata;
  endtask : xfer

endmodule : pdareg_host
`default_nettype wire

//--- testbench/pdareg_top_test.sv
// Purpose: self-checking bench for the demo register block
// Assumes: host model drives the bus; hready fed back from hreadyout
// Notes:   each table row writes an address then reads it back
`timescale 1ns/1ns
`default_nettype none

module pdareg_top_test;
  import pdareg_pkg::*;

  typedef struct packed {
    logic [31:0] a;
    logic [31:0] d;
    logic [31:0] e;
  } pdareg_row_s;

  localparam pdareg_row_s ROWS [11] = '{
    '{32'h0000_0010, 32'h0000_2A5C, 32'h0000_2A5C},
    '{32'h0000_0004, 32'h1234_5678, 32'h1234_5678},
    '{32'h0000_0008, 32'hFFFF_FFFF, 32'h0000_0000},
    '{32'h0000_000C, 32'h0000_00FF, 32'h0000_0000},
    '{32'h0001_1000, 32'hA5A5_0101, 32'hA5A5_0101},
    '{32'h0001_4FFC, 32'h5A5A_FEFE, 32'h5A5A_FEFE},
    '{32'h0001_1000, 32'h0F0F_F0F0, 32'h0F0F_F0F0},
    '{32'h0000_0014, 32'hFFFF_FFFF, 32'h0000_0000},
    '{32'h0001_0000, 32'h1111_1111, 32'h0000_0000},
    '{32'h0001_5000, 32'h2222_2222, 32'h0000_0000},
    '{32'h0000_0010, 32'hFFFF_FFFF, 32'h0000_3FFF}
  };
  localparam logic [7:0] SW [3] = '{8'h5A, 8'hC3, 8'hFF};

  logic                 hclk;
  logic                 hresetn;
  logic                 hsel;
  logic [ADDR_W-1:0]    haddr;
  logic [1:0]           htrans;
  logic                 hwrite;
  logic [2:0]           hsize;
  logic [DATA_W-1:0]    hwdata;
  logic [DATA_W-1:0]    hrdata;
  logic                 hreadyout;
  logic                 hresp;
  logic [SWITCH_W-1:0]  board_switch_bank;
  logic [SEGMENT_W-1:0] seg_out_n;
  logic [31:0]          v;
  logic [31:0]          w;
  int                   errors = 0;
  int                   n_checks = 0;

  pdareg_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .board_switch_bank(board_switch_bank), .seg_out_n(seg_out_n));

  pdareg_host host (.hclk(hclk), .hreadyout(hreadyout), .hrdata(hrdata),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata));

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic report_and_stop;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    host.xfer(1'h1, a, d, w);
  endtask : wr

  task automatic rd(input logic [31:0] a, output logic [31:0] d);
    host.xfer(1'h0, a, 32'h0, d);
  endtask : rd

  initial begin
    hclk = 1'h0;
    forever #20 hclk = ~hclk;
  end

  initial begin
    repeat (5000) @(posedge hclk);
    errors++;
    report_and_stop();
  end

  initial begin
    hresetn = 1'h0;
    board_switch_bank = 8'h00;
    repeat (5) @(posedge hclk);
    chk("reset pins", 32'h0000_FFFE, {16'h0, seg_out_n, hreadyout, hresp});
    hresetn <= 1'h1;
    foreach (ROWS[i]) begin
      wr(ROWS[i].a, ROWS[i].d);
      rd(ROWS[i].a, v);
      chk("row readback", ROWS[i].e, v);
      if (ROWS[i].a == 32'h0000_0010)
        chk("segment pins", {18'h0, ~ROWS[i].e[13:0]}, {18'h0, seg_out_n});
    end
    foreach (SW[i]) begin
      @(posedge hclk);
      board_switch_bank <= SW[i];
      rd(32'h0000_000C, v);
      chk("switches", {24'h0, SW[i]}, v);
    end
    // live count while running, one step per clock
    wr(32'h0000_0004, 32'h0000_03E8);
    wr(32'h0000_0000, 32'h0000_0001);
    rd(32'h0000_0008, v);
    rd(32'h0000_0008, w);
    chk("count start", 32'h0000_03E6, v);
    chk("count step", 32'h4, v - w);
    wr(32'h0000_0000, 32'h0000_0000);
    rd(32'h0000_0008, v);
    rd(32'h0000_0008, w);
    chk("count halted", v, w);
    wr(32'h0000_0004, 32'h0000_0002);
    wr(32'h0000_0000, 32'h0000_0001);
    // reads land every 4 clocks on a 2, 1, 0 cycle
    for (int k = 0; k < 6; k++) begin
      rd(32'h0000_0008, v);
      chk("count wrap", 32'(2 - (2 + 4 * k) % 3), v);
    end
    // reset in mid-run while counting
    @(posedge hclk);
    hresetn <= 1'h0;
    repeat (2) @(posedge hclk);
    chk("reset pins", 32'h0000_FFFE, {16'h0, seg_out_n, hreadyout, hresp});
    hresetn <= 1'h1;
    rd(32'h0000_0004, v);
    chk("reload reset", RELOAD_RST, v);
    rd(32'h0000_0008, v);
    chk("count reset", COUNT_RST, v);
    report_and_stop();
  end

endmodule : pdareg_top_test
`default_nettype wire
